// [clock_output_and_nco_config.sv]
// Operation
// - output 0 source select: 101 quarter system clock, 110 crystal, 111 divided fast clock
// - output 1 has an identical config register at its own offset
// - fast clock divided by 2*(divider+1) before it feeds an output
// - unlock flag bit 6 sets on lock loss, stays until written 1
// - lost-sync flag bit 5 sets on sync loss, cleared by writing 1
// - bit 4 shows live receive PLL lock, independent of receive data
// - bit 3 shows live physical layer ready to extract data
// - macro disable bit 0, active high level, inhibits the serial macro
// - increment bits 15:0 held in a 16-bit read-write register
// - increment bits 23:16 in low byte of a second register, rest reserved
// - both output config registers reset to 0007
// - increment low and high reset to d098 and 005e
// - force-zero bit set holds oscillator counters at zero
// - serial select 0 uses first oscillator strobe as serial port clock
//
// Our own choice: register access over AHB-Lite.

`include "clk_cfg_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module clock_output_and_nco_config #(
   parameter int INC_WIDTH = 24,
   parameter int DIV_WIDTH = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // clock sources, sampled as levels
   input wire logic fast_250mhz_clock,
   input wire logic xo_clock,
   // general-purpose clock outputs
   output logic general_clock_output0,
   output logic general_clock_output1,
   // serial macro
   input wire logic serial_pll_lock,
   input wire logic serial_phy_sync,
   output logic macro_disable,
   // oscillator strobes
   output logic oscillator1_strobe,
   output logic serial_mii_clock_strobe
);

   // --------------------------------------------------------------------
   // parameter checks
   // --------------------------------------------------------------------
   // high register holds the increment bits above 15 in its 16 bits
   if (INC_WIDTH < 17 || INC_WIDTH > 32) begin : g_bad_inc
      $error("INC_WIDTH must lie in 17..32");
   end
   if (DIV_WIDTH < 1 || DIV_WIDTH > 16) begin : g_bad_div
      $error("DIV_WIDTH must lie in 1..16");
   end

   // --------------------------------------------------------------------
   // helper functions
   // --------------------------------------------------------------------
   // map a byte address onto a register; upper address bits must be zero
   function automatic clk_cfg_pkg::reg_id_t decode(input logic [31:0] addr);
      clk_cfg_pkg::reg_id_t id;
      id = clk_cfg_pkg::REG_NONE;
      if (addr[31:16] == 16'h0000) begin
         unique case (addr[15:0])
            `OFS_GENERAL_CLOCK_OUT0_CONFIG: id = clk_cfg_pkg::REG_OUT0;
            `OFS_GENERAL_CLOCK_OUT1_CONFIG: id = clk_cfg_pkg::REG_OUT1;
            `OFS_SYSTEM_CLOCK_DIVIDER_CONFIG: id = clk_cfg_pkg::REG_DIVIDER;
            `OFS_SERIAL_MACRO_CONFIG_STATUS: id = clk_cfg_pkg::REG_SERIAL;
            `OFS_OSCILLATOR1_INCREMENT_LOW: id = clk_cfg_pkg::REG_INC_LOW;
            `OFS_OSCILLATOR1_INCREMENT_HIGH: id = clk_cfg_pkg::REG_INC_HIGH;
            `OFS_OSCILLATOR_CONTROL: id = clk_cfg_pkg::REG_OSC_CTRL;
            default: id = clk_cfg_pkg::REG_NONE;
         endcase
      end
      return id;
   endfunction

   // source mux shared by both general-purpose outputs
   function automatic logic pick_source(input logic [2:0] sel, input logic quarter,
                                        input logic xo, input logic divided);
      logic out;
      out = 1'b0;
      unique case (sel)
         `SEL_QUARTER_SYSTEM_CLOCK: out = quarter;
         `SEL_CRYSTAL_OSCILLATOR: out = xo;
         `SEL_DIVIDED_FAST_CLOCK: out = divided;
         default: out = 1'b0; // unused codes park the output low
      endcase
      return out;
   endfunction

   // --------------------------------------------------------------------
   // declarations
   // --------------------------------------------------------------------
   clk_cfg_pkg::bus_request_t pending;
   clk_cfg_pkg::reg_id_t rd_target;
   clk_cfg_pkg::serial_state_t serial;
   clk_cfg_pkg::osc_ctrl_t osc_ctrl;
   logic addr_phase;
   logic [2:0] out0_sel;
   logic [2:0] out1_sel;
   logic [DIV_WIDTH-1:0] fast_clock_divider;
   logic [15:0] inc_low;
   logic [INC_WIDTH-17:0] inc_high;
   logic [INC_WIDTH-1:0] increment;
   logic wr_out0;
   logic wr_out1;
   logic wr_div;
   logic wr_serial;
   logic wr_inc_low;
   logic wr_inc_high;
   logic wr_osc;
   logic [15:0] wdata;
   logic [15:0] next_rdata;
   logic [1:0] quarter_count;
   logic fast_prev;
   logic fast_rise;
   logic [DIV_WIDTH-1:0] div_count;
   logic divided_clock;
   logic lock_prev;
   logic sync_prev;
   logic osc1_raw;

   // --------------------------------------------------------------------
   // ahb-lite slave
   // --------------------------------------------------------------------
   // a transfer is taken only when selected, nonseq or seq, and hready
   assign addr_phase = hsel && htrans[1] && hready;

   // zero wait states and always okay, so both are constant flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (clk_en) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // capture the address phase for the following data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pending <= '{valid: 1'b0, write: 1'b0, target: clk_cfg_pkg::REG_NONE};
      end else if (clk_en) begin
         if (hready) begin
            pending.valid <= addr_phase;
            pending.write <= hwrite;
            pending.target <= decode(haddr);
         end
      end
   end

   // write strobes land at the end of the data phase, with hwdata
   assign wdata = hwdata[15:0];
   assign wr_out0 = pending.valid && pending.write && pending.target == clk_cfg_pkg::REG_OUT0;
   assign wr_out1 = pending.valid && pending.write && pending.target == clk_cfg_pkg::REG_OUT1;
   assign wr_div = pending.valid && pending.write && pending.target == clk_cfg_pkg::REG_DIVIDER;
   assign wr_serial = pending.valid && pending.write && pending.target == clk_cfg_pkg::REG_SERIAL;
   assign wr_inc_low = pending.valid && pending.write && pending.target == clk_cfg_pkg::REG_INC_LOW;
   assign wr_inc_high = pending.valid && pending.write && pending.target == clk_cfg_pkg::REG_INC_HIGH;
   assign wr_osc = pending.valid && pending.write && pending.target == clk_cfg_pkg::REG_OSC_CTRL;

   // read mux; reserved bits and unmapped addresses read zero
   assign rd_target = decode(haddr);
   always_comb begin
      next_rdata = 16'h0000;
      unique case (rd_target)
         clk_cfg_pkg::REG_OUT0: next_rdata[`OUT_SEL_MSB:`OUT_SEL_LSB] = out0_sel;
         clk_cfg_pkg::REG_OUT1: next_rdata[`OUT_SEL_MSB:`OUT_SEL_LSB] = out1_sel;
         clk_cfg_pkg::REG_DIVIDER: next_rdata[DIV_WIDTH-1:0] = fast_clock_divider;
         clk_cfg_pkg::REG_SERIAL: begin
            next_rdata[`SER_UNLOCK_BIT] = serial.unlock_sticky;
            next_rdata[`SER_LOST_SYNC_BIT] = serial.lost_sync_sticky;
            next_rdata[`SER_PLL_LOCK_BIT] = serial_pll_lock;
            next_rdata[`SER_PHY_SYNC_BIT] = serial_phy_sync;
            next_rdata[`SER_MACRO_DISABLE_BIT] = serial.macro_disable;
         end
         clk_cfg_pkg::REG_INC_LOW: next_rdata = inc_low;
         clk_cfg_pkg::REG_INC_HIGH: next_rdata[INC_WIDTH-17:0] = inc_high;
         clk_cfg_pkg::REG_OSC_CTRL: begin
            next_rdata[`OSC_FORCE_ZERO_BIT] = osc_ctrl.oscillator_force_zero;
            next_rdata[`OSC_SERIAL_SELECT_BIT] = osc_ctrl.serial_clock_oscillator_select;
         end
         clk_cfg_pkg::REG_NONE: next_rdata = 16'h0000;
      endcase
   end

   // read data is loaded at the address-phase edge, so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (clk_en) begin
         if (addr_phase && !hwrite) begin
            hrdata <= {16'h0000, next_rdata};
         end
      end
   end

   // --------------------------------------------------------------------
   // configuration registers
   // --------------------------------------------------------------------
   // only the select field is stored; bits 15:3 are reserved
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out0_sel <= 3'(`RST_GENERAL_CLOCK_OUT_CONFIG);
         out1_sel <= 3'(`RST_GENERAL_CLOCK_OUT_CONFIG);
      end else if (clk_en) begin
         if (wr_out0) begin
            out0_sel <= wdata[`OUT_SEL_MSB:`OUT_SEL_LSB];
         end
         if (wr_out1) begin
            out1_sel <= wdata[`OUT_SEL_MSB:`OUT_SEL_LSB];
         end
      end
   end

   // divider value for the fast clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_clock_divider <= DIV_WIDTH'(`RST_SYSTEM_CLOCK_DIVIDER_CONFIG);
      end else if (clk_en) begin
         if (wr_div) begin
            fast_clock_divider <= wdata[DIV_WIDTH-1:0];
         end
      end
   end

   // oscillator increment, split over two registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         inc_low <= `RST_OSCILLATOR1_INCREMENT_LOW;
         inc_high <= (INC_WIDTH-16)'(`RST_OSCILLATOR1_INCREMENT_HIGH);
      end else if (clk_en) begin
         if (wr_inc_low) begin
            inc_low <= wdata;
         end
         if (wr_inc_high) begin
            inc_high <= wdata[INC_WIDTH-17:0];
         end
      end
   end

   // the accumulator sees both halves at once; a two-write update may
   // run one or more cycles with a mixed value, harmless for an average rate
   assign increment = {inc_high, inc_low};

   // oscillator control bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_ctrl <= '0;
      end else if (clk_en) begin
         if (wr_osc) begin
            osc_ctrl.oscillator_force_zero <= wdata[`OSC_FORCE_ZERO_BIT];
            osc_ctrl.serial_clock_oscillator_select <= wdata[`OSC_SERIAL_SELECT_BIT];
         end
      end
   end

   // --------------------------------------------------------------------
   // serial macro status
   // --------------------------------------------------------------------
   // previous samples for falling-edge detection of lock and sync
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_prev <= 1'b0;
         sync_prev <= 1'b0;
      end else if (clk_en) begin
         lock_prev <= serial_pll_lock;
         sync_prev <= serial_phy_sync;
      end
   end

   // sticky flags: a new loss in the clearing cycle wins over the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial <= '0;
      end else if (clk_en) begin
         if (lock_prev && !serial_pll_lock) begin
            serial.unlock_sticky <= 1'b1;
         end else if (wr_serial && wdata[`SER_UNLOCK_BIT]) begin
            serial.unlock_sticky <= 1'b0;
         end
         if (sync_prev && !serial_phy_sync) begin
            serial.lost_sync_sticky <= 1'b1;
         end else if (wr_serial && wdata[`SER_LOST_SYNC_BIT]) begin
            serial.lost_sync_sticky <= 1'b0;
         end
         if (wr_serial) begin
            serial.macro_disable <= wdata[`SER_MACRO_DISABLE_BIT];
         end
      end
   end

   // inhibit macro
   // the level is passed straight on; bring-up stays with the macro
   assign macro_disable = serial.macro_disable;

   // --------------------------------------------------------------------
   // clock sources
   // --------------------------------------------------------------------
   // quarter system clock from a free two-bit counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         quarter_count <= 2'h0;
      end else if (clk_en) begin
         quarter_count <= quarter_count + 2'h1;
      end
   end

   // fast clock is a sampled level; only its rising edges count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_prev <= 1'b0;
      end else if (clk_en) begin
         fast_prev <= fast_250mhz_clock;
      end
   end
   assign fast_rise = fast_250mhz_clock && !fast_prev;

   // divide by 2*(n+1)
   // toggle every n+1 rising edges; >= keeps a lowered divider from
   // running the counter round its full range
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_count <= '0;
         divided_clock <= 1'b0;
      end else if (clk_en) begin
         if (fast_rise) begin
            if (div_count >= fast_clock_divider) begin
               div_count <= '0;
               divided_clock <= !divided_clock;
            end else begin
               div_count <= div_count + DIV_WIDTH'(1);
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         general_clock_output0 <= 1'b0;
         general_clock_output1 <= 1'b0;
      end else if (clk_en) begin
         general_clock_output0 <= pick_source(out0_sel, quarter_count[1], xo_clock, divided_clock);
         general_clock_output1 <= pick_source(out1_sel, quarter_count[1], xo_clock, divided_clock);
      end
   end

   // --------------------------------------------------------------------
   // oscillator
   // --------------------------------------------------------------------
   // accumulate and strobe
   nco_accumulator #(
      .WIDTH(INC_WIDTH)
   ) u_first_phase_accumulator (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_en(clk_en),
      .force_zero(osc_ctrl.oscillator_force_zero),
      .increment(increment),
      .strobe(osc1_raw)
   );

   // strobes re-registered so outputs come from flops here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oscillator1_strobe <= 1'b0;
         serial_mii_clock_strobe <= 1'b0;
      end else if (clk_en) begin
         oscillator1_strobe <= osc1_raw;
         // serial clock select
         // the second oscillator lives elsewhere, so select 1 gives no strobe here
         serial_mii_clock_strobe <= osc1_raw && !osc_ctrl.serial_clock_oscillator_select;
      end
   end

endmodule

`default_nettype wire

// [clk_cfg_regs.svh]
`ifndef CLK_CFG_REGS_SVH
`define CLK_CFG_REGS_SVH

// --------------------------------------------------------------------
// register byte offsets (low 16 bits of haddr, upper bits must be zero)
// --------------------------------------------------------------------
`define OFS_GENERAL_CLOCK_OUT0_CONFIG 16'hf948
`define OFS_GENERAL_CLOCK_OUT1_CONFIG 16'hf94c
`define OFS_SYSTEM_CLOCK_DIVIDER_CONFIG 16'hf950
`define OFS_SERIAL_MACRO_CONFIG_STATUS 16'hf954
`define OFS_OSCILLATOR1_INCREMENT_LOW 16'hf958
`define OFS_OSCILLATOR1_INCREMENT_HIGH 16'hf95c
`define OFS_OSCILLATOR_CONTROL 16'hf968

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define OUT_SEL_MSB 2
`define OUT_SEL_LSB 0
`define SEL_QUARTER_SYSTEM_CLOCK 3'h5
`define SEL_CRYSTAL_OSCILLATOR 3'h6
`define SEL_DIVIDED_FAST_CLOCK 3'h7
`define SER_UNLOCK_BIT 6
`define SER_LOST_SYNC_BIT 5
`define SER_PLL_LOCK_BIT 4
`define SER_PHY_SYNC_BIT 3
`define SER_MACRO_DISABLE_BIT 0
`define OSC_FORCE_ZERO_BIT 0
`define OSC_SERIAL_SELECT_BIT 1

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define RST_GENERAL_CLOCK_OUT_CONFIG 16'h0007
`define RST_SYSTEM_CLOCK_DIVIDER_CONFIG 16'h0000
`define RST_SERIAL_MACRO_CONFIG_STATUS 16'h0000
`define RST_OSCILLATOR1_INCREMENT_LOW 16'hd098
`define RST_OSCILLATOR1_INCREMENT_HIGH 16'h005e
`define RST_OSCILLATOR_CONTROL 16'h0000

`endif

// [clk_cfg_pkg.sv]
package clk_cfg_pkg;

   // register selected by a bus address
   typedef enum logic [2:0] {
      REG_NONE,
      REG_OUT0,
      REG_OUT1,
      REG_DIVIDER,
      REG_SERIAL,
      REG_INC_LOW,
      REG_INC_HIGH,
      REG_OSC_CTRL
   } reg_id_t;

   // address phase captured for the data phase
   typedef struct packed {
      logic valid;
      logic write;
      reg_id_t target;
   } bus_request_t;

   // serial macro configuration and status
   typedef struct packed {
      logic unlock_sticky;
      logic lost_sync_sticky;
      logic macro_disable;
   } serial_state_t;

   // oscillator control bits
   typedef struct packed {
      logic serial_clock_oscillator_select;
      logic oscillator_force_zero;
   } osc_ctrl_t;

endpackage

// [nco_accumulator.sv]
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------------------------
// phase accumulator: adds the increment every enabled cycle in which force_zero is low
// --------------------------------------------------------------------
module nco_accumulator #(
   parameter int WIDTH = 24
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // control
   input wire logic force_zero,
   input wire logic [WIDTH-1:0] increment,
   // result
   output logic strobe
);

   logic [WIDTH-1:0] phase;
   logic [WIDTH:0] next_sum;

   // carry out of the addition is the strobe
   assign next_sum = {1'b0, phase} + {1'b0, increment};

   // accumulator; force-zero parks both phase and strobe
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase <= '0;
         strobe <= 1'b0;
      end else if (clk_en) begin
         if (force_zero) begin
            phase <= '0;
            strobe <= 1'b0;
         end else begin
            phase <= next_sum[WIDTH-1:0];
            strobe <= next_sum[WIDTH];
         end
      end
   end

endmodule

`default_nettype wire

// [clock_output_and_nco_config_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// port-level checks of bus answers and status bits
// ------------------------------------------------
module clock_output_and_nco_config_assertions #(
   parameter int INC_WIDTH = 24,
   parameter int DIV_WIDTH = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // clocks and serial macro
   input wire logic fast_250mhz_clock,
   input wire logic xo_clock,
   input wire logic general_clock_output0,
   input wire logic general_clock_output1,
   input wire logic serial_pll_lock,
   input wire logic serial_phy_sync,
   input wire logic macro_disable,
   // strobes
   input wire logic oscillator1_strobe,
   input wire logic serial_mii_clock_strobe
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // address phase accepted at this edge
   wire logic take = hsel && htrans[1] && hready && clk_en;
   property p_zero_wait; hreadyout; endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("hreadyout low");
   property p_okay; !hresp; endproperty
   a_okay: assert property (p_okay) else $error("hresp not okay");
   property p_upper; hrdata[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper) else $error("hrdata upper half set");
   property p_live; take && !hwrite && haddr == 32'h0000f954
      |=> hrdata[4] == $past(serial_pll_lock) && hrdata[3] == $past(serial_phy_sync); endproperty
   a_live: assert property (p_live) else $error("live status bits wrong");
   property p_unmapped; take && !hwrite && haddr == 32'h0000f960 |=> hrdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_reserved; take && !hwrite && haddr == 32'h0000f95c |=> hrdata[15:8] == 8'h00; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved high bits set");
   property p_mii; serial_mii_clock_strobe |-> oscillator1_strobe; endproperty
   a_mii: assert property (p_mii) else $error("serial strobe without oscillator strobe");
   // disable level follows bit 0 of the data phase one edge later
   property p_disable; take && hwrite && haddr == 32'h0000f954 ##1 clk_en
      |=> macro_disable == $past(hwdata[0]); endproperty
   a_disable: assert property (p_disable) else $error("macro disable not written");
   c_status_read: cover property (take && !hwrite && haddr == 32'h0000f954);
   c_osc: cover property (oscillator1_strobe);
   c_mii: cover property (serial_mii_clock_strobe);
endmodule
bind clock_output_and_nco_config clock_output_and_nco_config_assertions #(
   .INC_WIDTH(INC_WIDTH), .DIV_WIDTH(DIV_WIDTH)) i_chk (
   .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .fast_250mhz_clock(fast_250mhz_clock), .xo_clock(xo_clock),
   .general_clock_output0(general_clock_output0), .general_clock_output1(general_clock_output1),
   .serial_pll_lock(serial_pll_lock), .serial_phy_sync(serial_phy_sync),
   .macro_disable(macro_disable), .oscillator1_strobe(oscillator1_strobe),
   .serial_mii_clock_strobe(serial_mii_clock_strobe));
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic hclk, hresetn, clk_en, hsel, hwrite, fast_clk, xo_clk, pll_lock, phy_sync;
   logic hreadyout, hresp, gco0, gco1, mdis, osc_stb, mii_stb;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] lfsr_state = 16'hc647;
   int n_errors = 0, samples_checked = 0, cycles = 0;
   int model[int];
   logic [15:0] addrs [7] = '{16'hf948, 16'hf94c, 16'hf950, 16'hf954, 16'hf958, 16'hf95c, 16'hf960};
   logic [31:0] rstv [7] = '{32'h7, 32'h7, 32'h0, 32'h18, 32'hd098, 32'h5e, 32'h0};
   logic [31:0] keep [7] = '{32'h7, 32'h7, 32'hff, 32'h1, 32'hffff, 32'hff, 32'h0};
   logic [2:0] sels [5] = '{3'h0, 3'h5, 3'h6, 3'h7, 3'h7};

   clock_output_and_nco_config i_clock_output_and_nco_config (.hclk(hclk), .hresetn(hresetn),
      .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .fast_250mhz_clock(fast_clk), .xo_clock(xo_clk), .general_clock_output0(gco0),
      .general_clock_output1(gco1), .serial_pll_lock(pll_lock), .serial_phy_sync(phy_sync),
      .macro_disable(mdis), .oscillator1_strobe(osc_stb), .serial_mii_clock_strobe(mii_stb));

   // -----------------------------------
   // clock, source clocks and time limit
   // -----------------------------------
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // sources are sampled levels, so they only move on hclk edges
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      fast_clk <= ~fast_clk;
      if (cycles % 3 == 0) xo_clk <= ~xo_clk;
      if (cycles == 30000) begin
         n_errors++;
         complete_run();
      end
   end

   // ------------------------
   // bus, compare and counts
   // ------------------------
   function automatic logic [15:0] rnd();
      lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
      return lfsr_state;
   endfunction
   // one single transfer; zero wait states still honoured by polling hreadyout
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {16'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   // counts allow one edge of slack for the window phase
   task automatic check_count(input string what, input int exp, input int got);
      samples_checked++;
      if (got < exp - 1 || got > exp + 1) begin
         n_errors++;
         $display("unexpected %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [15:0] a);
      xfer(1'b0, a, 32'h0);
      check_val("register read", model[a], rd);
   endtask
   task automatic count_rises(input int sel, input int n, output int cnt);
      logic prev, now;
      cnt = 0;
      prev = 1'b0;
      repeat (n) begin
         @(negedge hclk);
         now = sel == 0 ? gco0 : sel == 1 ? gco1 : sel == 2 ? osc_stb : mii_stb;
         if (now === 1'b1 && prev !== 1'b1) cnt++;
         prev = now;
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // --------------
   // main sequence
   // --------------
   initial begin
      int c, e;
      logic [31:0] d, inc;
      hresetn = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      fast_clk = 1'b0;
      xo_clk = 1'b0;
      pll_lock = 1'b1;
      phy_sync = 1'b1;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         model[addrs[i]] = rstv[i];
         rd_chk(addrs[i]);
      end
      // random writes, reserved bits dropped, unmapped ignored
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 7; i++) begin
            d = (i >= 4) ? {16'h0, rnd()} : {16'h0, rnd()} & keep[i];
            if (i == 3) continue;
            xfer(1'b1, addrs[i], d);
            model[addrs[i]] = d & keep[i];
            rd_chk(addrs[i]);
         end
      end
      xfer(1'b1, 16'hf954, 32'h1);
      model[16'hf954] = 32'h19;
      rd_chk(16'hf954);
      check_val("macro disable", 32'h1, {31'h0, mdis});
      pll_lock <= 1'b0;
      repeat (3) @(posedge hclk);
      model[16'hf954] = 32'h49;
      rd_chk(16'hf954);
      pll_lock <= 1'b1;
      phy_sync <= 1'b0;
      repeat (3) @(posedge hclk);
      model[16'hf954] = 32'h71;
      rd_chk(16'hf954);
      phy_sync <= 1'b1;
      repeat (3) @(posedge hclk);
      model[16'hf954] = 32'h79;
      rd_chk(16'hf954);
      xfer(1'b1, 16'hf954, 32'h40);
      model[16'hf954] = 32'h38;
      rd_chk(16'hf954);
      xfer(1'b1, 16'hf954, 32'h20);
      model[16'hf954] = 32'h18;
      rd_chk(16'hf954);
      check_val("macro disable", 32'h0, {31'h0, mdis});
      xfer(1'b1, 16'hf968, 32'h1);
      count_rises(2, 100, c);
      check_count("forced strobes", 0, c);
      for (int j = 0; j < 2; j++) begin
         inc = j == 0 ? 32'h5ed098 : 32'h800000;
         xfer(1'b1, 16'hf958, inc & 32'hffff);
         xfer(1'b1, 16'hf95c, inc >> 16);
         xfer(1'b1, 16'hf968, 32'h0);
         e = int'((64'd1000 * inc) >> 24); // rate is increment over 2^24
         count_rises(2, 1000, c);
         check_count("oscillator strobes", e, c);
         count_rises(3, 1000, c);
         check_count("serial strobes", e, c);
      end
      xfer(1'b1, 16'hf968, 32'h2);
      count_rises(3, 200, c);
      check_count("deselected serial strobes", 0, c);
      for (int o = 0; o < 2; o++) begin
         for (int s = 0; s < 5; s++) begin
            xfer(1'b1, 16'hf950, s == 4 ? 3 : 0);
            xfer(1'b1, 16'hf948 + 16'(4 * o), {29'h0, sels[s]});
            count_rises(o, 64, c);
            e = sels[s] == 5 ? 16 : sels[s] == 6 ? 11 : sels[s] == 7 ? 64 / (4 * ((s == 4 ? 3 : 0) + 1)) : 0;
            check_count("clock output edges", e, c);
         end
      end
      @(posedge hclk) clk_en <= 1'b0;
      count_rises(2, 100, c);
      check_count("frozen strobes", 0, c);
      complete_run();
   end
endmodule
`default_nettype wire
